// [hdl/scpc_top.v]
/*
 System clock synthesizer control: shadowed configuration registers, update
 strobe, power-up and manual VCO calibration handshake, lock reporting,
 millisecond stability hold-off and compensation routing.
 Assumes the analog synthesizer reports lock and calibration completion as
 asynchronous levels, and a register master that never waits.
*/
`timescale 1ns/1ps
`include "scpc_map.vh"

module scpc_top #(
    parameter CYC_PER_MS = `SCPC_CYC_PER_MS,
    parameter CAL_CYCLES = `SCPC_CAL_CYCLES
) (
    input wire i_clk_sys,
    input wire i_rst_n,
    input wire i_ce,
    input wire [13:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    input wire i_synth_lock_raw,
    input wire i_cal_done_raw,
    output reg o_cal_start,
    output reg o_osc_amp_enable,
    output reg o_input_doubler_enable,
    output reg [1:0] o_input_prescale_select,
    output reg [7:0] o_feedback_ratio,
    output reg [39:0] o_ref_freq_declared,
    output reg o_synth_stable_flag,
    output reg o_comp_apply,
    output reg o_comp_source_sel
);
    localparam ST_INIT = 4'b0001;
    localparam ST_CAL = 4'b0010;
    localparam ST_RUN = 4'b0100;
    localparam ST_WAIT = 4'b1000;

    // Shadow copies, written by software
    reg [7:0] sh_fb;
    reg [7:0] sh_path;
    reg [7:0] sh_ref [0:4];
    reg [7:0] sh_hold [0:2];
    reg [7:0] sh_cal;
    reg [7:0] sh_comp;
    // Active copies, loaded on update
    reg [19:0] act_hold;
    reg act_cal_req;
    reg cal_req_q;
    reg [3:0] state;
    reg [3:0] next_state;
    reg [15:0] cal_cnt;
    reg [16:0] ms_cnt;
    reg [19:0] hold_cnt;
    reg lock_s1, lock_s2, done_s1, done_s2;
    reg init_done;
    wire upd = i_wr && (i_addr == `SCPC_OFF_UPDATE);
    wire busy = (state == ST_CAL) || (state == ST_WAIT);
    integer k;

    // Pin synchronisers; first stage feeds only the second
    always @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            lock_s1 <= 1'b0;
            lock_s2 <= 1'b0;
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
        end
        else if (i_ce)
        begin
            lock_s1 <= i_synth_lock_raw;
            lock_s2 <= lock_s1;
            done_s1 <= i_cal_done_raw;
            done_s2 <= done_s1;
        end
    end

    // Shadow register writes
    always @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            sh_fb <= `SCPC_RST_FB_RATIO;
            sh_path <= `SCPC_RST_IN_PATH;
            sh_cal <= 8'h00;
            sh_comp <= 8'h00;
            for (k = 0; k < 5; k = k + 1)
                sh_ref[k] <= 8'h00;
            for (k = 0; k < 3; k = k + 1)
                sh_hold[k] <= 8'h00;
        end
        else if (i_ce && i_wr)
        begin
            case (i_addr)
                `SCPC_OFF_FB_RATIO: sh_fb <= i_wdata;
                `SCPC_OFF_IN_PATH: sh_path <= i_wdata;
                `SCPC_OFF_CAL_CTRL: sh_cal <= i_wdata;
                `SCPC_OFF_COMP_CTRL: sh_comp <= i_wdata;
                default:
                begin
                    for (k = 0; k < 5; k = k + 1)
                        if (i_addr == `SCPC_OFF_REF_FREQ0 + k[13:0])
                            sh_ref[k] <= i_wdata;
                    for (k = 0; k < 3; k = k + 1)
                        if (i_addr == `SCPC_OFF_HOLDOFF0 + k[13:0])
                            sh_hold[k] <= i_wdata;
                end
            endcase
        end
    end

    // Transfer shadow to active on the update strobe only
    always @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            o_feedback_ratio <= `SCPC_RST_FB_RATIO;
            o_osc_amp_enable <= 1'b0;
            o_input_doubler_enable <= 1'b0;
            o_input_prescale_select <= 2'b00;
            o_ref_freq_declared <= 40'h0000000000;
            act_hold <= `SCPC_RST_HOLDOFF;
            act_cal_req <= 1'b0;
            o_comp_apply <= 1'b0;
            o_comp_source_sel <= 1'b0;
        end
        else if (i_ce && upd)
        begin
            o_feedback_ratio <= sh_fb;
            o_osc_amp_enable <= sh_path[`SCPC_BIT_XTAL];
            o_input_doubler_enable <= sh_path[`SCPC_BIT_DOUBLER];
            o_input_prescale_select <= sh_path[`SCPC_BIT_PRE_HI:`SCPC_BIT_PRE_LO];
            o_ref_freq_declared <= {sh_ref[4], sh_ref[3], sh_ref[2], sh_ref[1], sh_ref[0]};
            act_hold <= {sh_hold[2][3:0], sh_hold[1], sh_hold[0]};
            act_cal_req <= sh_cal[`SCPC_BIT_CAL];
            // Channel 0 or 1 as the stable source, bit 0 enables compensation
            o_comp_apply <= sh_comp[0];
            o_comp_source_sel <= sh_comp[1];
        end
    end

    // Calibration sequencer: power-up pass, then rising edges of the request bit
    always @*
    begin
        next_state = state;
        case (state)
            ST_INIT: next_state = ST_CAL;
            ST_CAL: next_state = ST_WAIT;
            // Done is ignored for the first cycles: the synchroniser still shows the previous pass
            ST_WAIT:
                if ((done_s2 && cal_cnt > 16'h0002) || cal_cnt == CAL_CYCLES[15:0])
                    next_state = ST_RUN;
            // Only a fresh request recalibrates; nothing else re-enters calibration
            ST_RUN:
                if (act_cal_req && !cal_req_q)
                    next_state = ST_CAL;
            default: next_state = ST_INIT;
        endcase
    end

    // Sequencer state; timeout guards against a calibrator that never answers
    always @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            state <= ST_INIT;
            cal_cnt <= 16'h0000;
            cal_req_q <= 1'b0;
            o_cal_start <= 1'b0;
            init_done <= 1'b0;
        end
        else if (i_ce)
        begin
            state <= next_state;
            cal_req_q <= act_cal_req;
            o_cal_start <= (next_state == ST_CAL);
            cal_cnt <= (state == ST_WAIT) ? cal_cnt + 16'h0001 : 16'h0000;
            if (state == ST_WAIT && next_state == ST_RUN)
                init_done <= 1'b1;
        end
    end

    // Hold-off timer counts whole milliseconds of continuous lock
    always @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            ms_cnt <= 17'h00000;
            hold_cnt <= 20'h00000;
            o_synth_stable_flag <= 1'b0;
        end
        else if (i_ce)
        begin
            if (!lock_s2 || busy || !init_done || act_hold == 20'h00000)
            begin
                // Any loss of lock restarts the whole hold-off
                ms_cnt <= 17'h00000;
                hold_cnt <= 20'h00000;
                o_synth_stable_flag <= 1'b0;
            end
            else if (hold_cnt >= act_hold)
                o_synth_stable_flag <= 1'b1;
            else if (ms_cnt == CYC_PER_MS[16:0] - 17'h00001)
            begin
                ms_cnt <= 17'h00000;
                hold_cnt <= hold_cnt + 20'h00001;
            end
            else
                ms_cnt <= ms_cnt + 17'h00001;
        end
    end

    // Read port; unmapped addresses read zero
    always @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
            o_rdata <= 8'h00;
        else if (i_ce)
        begin
            o_rdata <= 8'h00;
            if (i_rd)
            begin
                case (i_addr)
                    `SCPC_OFF_FB_RATIO: o_rdata <= sh_fb;
                    `SCPC_OFF_IN_PATH: o_rdata <= sh_path;
                    `SCPC_OFF_CAL_CTRL: o_rdata <= sh_cal;
                    `SCPC_OFF_COMP_CTRL: o_rdata <= sh_comp;
                    // Status: locked, stable, busy
                    `SCPC_OFF_STATUS: o_rdata <= {5'h00, busy, o_synth_stable_flag, lock_s2};
                    default:
                    begin
                        for (k = 0; k < 5; k = k + 1)
                            if (i_addr == `SCPC_OFF_REF_FREQ0 + k[13:0])
                                o_rdata <= sh_ref[k];
                        for (k = 0; k < 3; k = k + 1)
                            if (i_addr == `SCPC_OFF_HOLDOFF0 + k[13:0])
                                o_rdata <= sh_hold[k];
                    end
                endcase
            end
        end
    end
endmodule

// [shared/scpc_map.vh]
/*
 Register offsets, field positions, reset values and timing counts for the
 system clock synthesizer control block.
 Assumes a single 10 MHz system clock and a plain register port with
 read data returned one cycle after the read strobe.
*/
// Notes on behaviour
// - Input path bit: 0 selects direct path (default), 1 enables crystal amplifier.
// - Doubler bit set doubles the reference before the phase detector.
// - Two-bit prescale divides by two to the field value; default ratio one.
// - Eight-bit feedback ratio used directly, no offset; valid 4 to 255.
// - Lock detector result shows in status bit 0: 1 locked.
// - Report unstable after power-up until configuration, calibration and lock complete.
// - Stable asserts only after a 20-bit millisecond hold-off following lock.
// - Hold-off field zero forces unstable regardless of lock.
// - Stable indication goes to a status bit and to timekeeping blocks.
// - Calibration runs automatically during power-up initialization.
// - Calibration busy status bit 2 stays high while calibrating.
// - Leaving power-down needs no synthesizer recalibration.
// - Compensation from a stable loop channel can be applied to the other channel.
`ifndef SCPC_MAP_VH
`define SCPC_MAP_VH
`define SCPC_ADDR_W 14
`define SCPC_OFF_FB_RATIO 14'h0200
`define SCPC_OFF_IN_PATH 14'h0201
`define SCPC_OFF_REF_FREQ0 14'h0202
`define SCPC_OFF_HOLDOFF0 14'h0207
`define SCPC_OFF_CAL_CTRL 14'h2000
`define SCPC_OFF_UPDATE 14'h000f
`define SCPC_OFF_COMP_CTRL 14'h2001
`define SCPC_OFF_STATUS 14'h3001
`define SCPC_BIT_DOUBLER 0
`define SCPC_BIT_PRE_LO 1
`define SCPC_BIT_PRE_HI 2
`define SCPC_BIT_XTAL 3
`define SCPC_BIT_CAL 2
`define SCPC_BIT_LOCKED 0
`define SCPC_BIT_STABLE 1
`define SCPC_BIT_BUSY 2
`define SCPC_RST_FB_RATIO 8'h00
`define SCPC_RST_IN_PATH 8'h00
`define SCPC_RST_HOLDOFF 20'h00000
`define SCPC_CLK_HZ 10000000
`define SCPC_MS_PER_S 1000
`define SCPC_CYC_PER_MS (`SCPC_CLK_HZ / `SCPC_MS_PER_S)
`define SCPC_CAL_CYCLES 16'h0400
`endif

// [sim/scpc_sva.sv]
/* Port checker for scpc_top.
 Assumes one clock, synchronous active-low reset. */
`timescale 1ns/1ps
module scpc_sva #(parameter CYC_PER_MS = 10) (
    input wire i_clk_sys,
    input wire i_rst_n,
    input wire i_ce,
    input wire [13:0] i_addr,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] o_rdata,
    input wire i_synth_lock_raw,
    input wire o_cal_start,
    input wire o_osc_amp_enable,
    input wire o_input_doubler_enable,
    input wire [1:0] o_input_prescale_select,
    input wire [7:0] o_feedback_ratio,
    input wire o_synth_stable_flag
);
default clocking cb @(posedge i_clk_sys); endclocking
default disable iff (!i_rst_n);
// Update strobe and the path fields it commits
wire upd = i_ce && i_wr && i_addr == 14'h000f;
wire [3:0] path = {o_osc_amp_enable, o_input_prescale_select, o_input_doubler_enable};
// Lock gone long enough to clear the synchronizer
sequence s_lock_lost;
    !i_synth_lock_raw [*4];
endsequence
a_rdata_idle: assert property (i_ce && !i_rd |=> o_rdata == 8'h00)
    else $error("read data not idle");
a_fb_hold: assert property ($changed(o_feedback_ratio) |-> $past(upd))
    else $error("ratio moved without update");
a_path_hold: assert property ($changed(path) |-> $past(upd))
    else $error("path moved without update");
a_cal_once: assert property (o_cal_start |=> !o_cal_start [*4])
    else $error("calibration start repeated");
a_startup_cal: assert property ($rose(i_rst_n) |-> ##[1:3] o_cal_start)
    else $error("no calibration after reset");
a_stable_drop: assert property (s_lock_lost |=> !o_synth_stable_flag)
    else $error("stable without lock");
a_stable_wait: assert property ($rose(o_synth_stable_flag) |-> $past(i_synth_lock_raw, CYC_PER_MS))
    else $error("stable before hold-off");
a_stable_cal: assert property (o_cal_start |-> ##2 !o_synth_stable_flag [*4])
    else $error("stable while calibrating");
endmodule
bind scpc_top scpc_sva #(.CYC_PER_MS(CYC_PER_MS)) scpc_sva_inst (.i_clk_sys, .i_rst_n, .i_ce, .i_addr,
    .i_wr, .i_rd, .o_rdata, .i_synth_lock_raw, .o_cal_start, .o_osc_amp_enable, .o_input_doubler_enable,
    .o_input_prescale_select, .o_feedback_ratio, .o_synth_stable_flag);

// [sim/scpc_synth_model.sv]
/* Stand-in for the analog synthesizer: calibrates on request, then locks.
 Assumes the control block synchronizes both levels. */
`timescale 1ns/1ps
module scpc_synth_model (
    input wire i_clk_sys,
    input wire i_cal_start,
    input wire i_slow,
    input wire i_unlock,
    output reg o_lock = 1'b0,
    output reg o_cal_done = 1'b0
);
reg [4:0] cnt = 5'h00;
// Done and lock are earned only by a calibration, so a missing start hangs
always @(posedge i_clk_sys)
begin
    if (i_cal_start)
        cnt <= 5'h01;
    else if (cnt != 5'h00 && cnt != 5'h1f)
        cnt <= cnt + 5'h01;
    o_cal_done <= !i_cal_start && cnt >= (i_slow ? 5'h0e : 5'h08);
    o_lock <= !i_cal_start && cnt >= 5'h14 && !i_unlock;
end
endmodule

// [sim/tb_scpc_top.sv]
/* Self-checking bench for scpc_top with the synthesizer stand-in.
 Assumes 10-cycle milliseconds and a 16-cycle calibration limit. */
`timescale 1ns/1ps
module tb_scpc_top;
reg clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, unlock = 1'b0, slow = 1'b0, ce = 1'b1;
wire comp_a, comp_s;
reg [13:0] addr = 14'h0000;
reg [7:0] wdata = 8'h00, r;
wire [7:0] rdata, fb;
wire [1:0] pre;
wire [39:0] rf;
wire lock, done, cal, amp, dbl, stable;
integer failures = 0, comparisons = 0, cyc = 0, i, j, k;
scpc_top #(.CYC_PER_MS(10), .CAL_CYCLES(16)) scpc_top_inst (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(ce),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_synth_lock_raw(lock),
    .i_cal_done_raw(done), .o_cal_start(cal), .o_osc_amp_enable(amp), .o_input_doubler_enable(dbl),
    .o_input_prescale_select(pre), .o_feedback_ratio(fb), .o_ref_freq_declared(rf),
    .o_synth_stable_flag(stable), .o_comp_apply(comp_a), .o_comp_source_sel(comp_s));
scpc_synth_model scpc_synth_model_inst (.i_clk_sys(clk), .i_cal_start(cal), .i_slow(slow),
    .i_unlock(unlock), .o_lock(lock), .o_cal_done(done));
initial forever #50 clk = ~clk;
task print_verdict;
begin
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
        $display("DONE - PASS");
    else
        $display("DONE - FAIL");
    $finish;
end
endtask
// Hang guard, far above the few hundred cycles the run needs
always @(posedge clk)
begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
        failures = failures + 1;
        print_verdict;
    end
end
task chk(input [39:0] got, input [39:0] exp);
begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
        failures = failures + 1;
        $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
end
endtask
task wr_reg(input [13:0] a, input [7:0] d);
begin
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
end
endtask
// Read data stand only in the cycle after the strobe
task rd_reg(input [13:0] a);
begin
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    r = rdata;
end
endtask
task upd;
begin
    wr_reg(14'h000f, 8'h00);
    @(posedge clk);
    #1;
end
endtask
task wait_st(input logic e);
begin
    for (k = 0; k < 300 && stable !== e; k = k + 1)
        @(posedge clk);
    #1;
end
endtask
task t_reset;
begin
    chk(stable, 0);
    chk({amp, dbl, pre, fb}, 0);
    repeat (40) @(posedge clk);
    rd_reg(14'h3001);
    chk(r[2:0], 3'b001);
    rd_reg(14'h0123);
    chk(r, 0);
end
endtask
// Every prescale code, ratio boundaries 4 and 255, shadowing before update
task t_config;
begin
    for (i = 0; i < 5; i = i + 1)
        wr_reg(14'h0202 + i[13:0], 8'(17 * i + 17));
    for (j = 0; j < 4; j = j + 1)
    begin
        wr_reg(14'h0200, 8'(j == 3 ? 255 : 4 + 85 * j));
        wr_reg(14'h0201, {4'h0, j[0], j[1:0], ~j[0]});
        chk(fb, j == 0 ? 0 : 85 * j - 81);
        upd;
        chk({amp, pre, dbl, fb}, {j[0], j[1:0], ~j[0], 8'(j == 3 ? 255 : 4 + 85 * j)});
    end
    chk(rf, 40'h5544332211);
end
endtask
// Enable low must freeze everything, then compensation routing once running again
task t_freeze;
begin
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(14'h0200, 8'h55);
    wr_reg(14'h000f, 8'h00);
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    #1;
    chk(fb, 8'hff);
    rd_reg(14'h0200);
    chk(r, 8'hff);
    wr_reg(14'h2001, 8'h03);
    upd;
    chk({comp_a, comp_s}, 2'b11);
end
endtask
task t_stable;
begin
    wr_reg(14'h0207, 8'h01);
    wr_reg(14'h0208, 8'h00);
    wr_reg(14'h0209, 8'h00);
    upd;
    wait_st(1);
    rd_reg(14'h3001);
    chk({stable, r[2:0]}, 4'hb);
    @(posedge clk);
    unlock <= 1'b1;
    wait_st(0);
    rd_reg(14'h3001);
    chk({stable, r[1:0]}, 3'b000);
    @(posedge clk);
    unlock <= 1'b0;
    wait_st(1);
    wr_reg(14'h0207, 8'h00);
    upd;
    wait_st(0);
    rd_reg(14'h3001);
    chk({stable, r[1:0]}, 3'b001);
end
endtask
// Prompt then slow answer; writing zero rearms the start bit
task t_cal;
begin
    wr_reg(14'h0207, 8'h01);
    upd;
    for (i = 0; i < 2; i = i + 1)
    begin
        @(posedge clk);
        slow <= i[0];
        wr_reg(14'h2000, 8'h04);
        upd;
        rd_reg(14'h3001);
        chk(r[2:1], 2'b10);
        wr_reg(14'h2000, 8'h00);
        upd;
        wait_st(1);
        rd_reg(14'h3001);
        chk(r[2:0], 3'b011);
    end
end
endtask
initial
begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    t_reset;
    t_config;
    t_freeze;
    t_stable;
    t_cal;
    print_verdict;
end
endmodule
